/* File: src/tmr_top.sv */
// Contract
// - control bits 7:4 pick the counting source clock
// - control bits 3:2 route the timer output to one of three pins
// - pre-scaler divides the source by 1, 4, 16 or 64 from scaler bits 6:5
// - second stage divides by scaler bits 4:0 plus one, giving the tick
// - counter counts up on each tick; software loads and reads it
// - in period mode the counter returns to zero when it reaches the bound value
// - two modes: period mode and pwm mode
// - period mode output is a 50 percent square wave
// - control bit 1 selects pwm; scaler bit 7 clear gives 256-tick period
// - 8-bit pwm output is high for bound plus one of 256 ticks
// - scaler bit 7 set gives 6-bit pwm with a 64-tick period
`timescale 1ns/1ps
module tmr_top (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       fast_internal_osc,
   input  wire logic       slow_internal_osc,
   input  wire logic       crystal_osc,
   input  wire logic       comparator_out,
   input  wire logic       clk_in_pin_a,
   input  wire logic       clk_in_pin_b,
   input  wire logic       clk_in_pin_c,
   output logic            out_pin_a,
   output logic            out_pin_a_oe,
   output logic            out_pin_b,
   output logic            out_pin_b_oe,
   output logic            out_pin_c,
   output logic            out_pin_c_oe,
   output logic            irq
);
   // software registers
   logic [7:0] timer_control_r;
   logic [7:0] timer_scaler_r;
   logic [7:0] timer_counter_value_r;
   logic [7:0] timer_bound_r;
   logic [1:0] int_stat_r;
   logic [1:0] int_mask_r;

   // waveform state
   logic       wave_r;
   logic [7:0] counter_nxt;
   logic       wave_nxt;
   logic       wrap_evt;
   logic       pwm_evt;

   // decoded fields
   logic [3:0] src_sel;
   logic [1:0] pin_sel;
   logic       pwm_mode;
   logic       pwm_6bit;
   logic [7:0] pwm_last;

   // bus decode
   logic       wr_control;
   logic       wr_scaler;
   logic       wr_counter;
   logic       wr_bound;
   logic       wr_mask;
   logic       rd_stat;

   // source edges
   logic [tmr_pkg::NUM_EXT-1:0] ext_level;
   logic [tmr_pkg::NUM_EXT-1:0] ext_rise;
   logic                        src_tick;

   tmr_tick_if tif ();

   assign src_sel  = timer_control_r[tmr_pkg::CTL_SRC_HI:tmr_pkg::CTL_SRC_LO];
   assign pin_sel  = timer_control_r[tmr_pkg::CTL_PIN_HI:tmr_pkg::CTL_PIN_LO];
   assign pwm_mode = timer_control_r[tmr_pkg::CTL_PWM_BIT];
   assign pwm_6bit = timer_scaler_r[tmr_pkg::SCL_6BIT_BIT];
   assign pwm_last = pwm_6bit ? tmr_pkg::PWM6_LAST : tmr_pkg::PWM8_LAST;

   assign wr_control = wr_en && (addr == tmr_pkg::OFF_CONTROL);
   assign wr_scaler  = wr_en && (addr == tmr_pkg::OFF_SCALER);
   assign wr_counter = wr_en && (addr == tmr_pkg::OFF_COUNTER);
   assign wr_bound   = wr_en && (addr == tmr_pkg::OFF_BOUND);
   assign wr_mask    = wr_en && (addr == tmr_pkg::OFF_INT_MASK);
   assign rd_stat    = rd_en && (addr == tmr_pkg::OFF_INT_STAT);

   // ------------------------------------------------------------------
   // clock source selection
   // ------------------------------------------------------------------
   always_comb begin
      ext_level                        = '0;
      ext_level[tmr_pkg::EXT_FAST]     = fast_internal_osc;
      ext_level[tmr_pkg::EXT_SLOW]     = slow_internal_osc;
      ext_level[tmr_pkg::EXT_CRYSTAL]  = crystal_osc;
      ext_level[tmr_pkg::EXT_COMPARE]  = comparator_out;
      ext_level[tmr_pkg::EXT_PIN_A]    = clk_in_pin_a;
      ext_level[tmr_pkg::EXT_PIN_B]    = clk_in_pin_b;
      ext_level[tmr_pkg::EXT_PIN_C]    = clk_in_pin_c;
   end

   // sources slower than clk are counted on their rising edges
   tmr_edge_det #(
      .WIDTH    (tmr_pkg::NUM_EXT)
   ) u_edges (
      .clk      (clk),
      .rst      (rst),
      .level_in (ext_level),
      .rise     (ext_rise)
   );

   always_comb begin
      unique case (src_sel)
         tmr_pkg::SRC_SYSCLK:   src_tick = 1'b1;
         tmr_pkg::SRC_FAST_OSC: src_tick = ext_rise[tmr_pkg::EXT_FAST];
         tmr_pkg::SRC_SLOW_OSC: src_tick = ext_rise[tmr_pkg::EXT_SLOW];
         tmr_pkg::SRC_CRYSTAL:  src_tick = ext_rise[tmr_pkg::EXT_CRYSTAL];
         tmr_pkg::SRC_COMPARE:  src_tick = ext_rise[tmr_pkg::EXT_COMPARE];
         tmr_pkg::SRC_PIN_A:    src_tick = ext_rise[tmr_pkg::EXT_PIN_A];
         tmr_pkg::SRC_PIN_B:    src_tick = ext_rise[tmr_pkg::EXT_PIN_B];
         tmr_pkg::SRC_PIN_C:    src_tick = ext_rise[tmr_pkg::EXT_PIN_C];
         default:               src_tick = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // pre-scaler and scaler
   // ------------------------------------------------------------------
   assign tif.src_tick  = src_tick;
   assign tif.pre_sel   = timer_scaler_r[tmr_pkg::SCL_PRE_HI:tmr_pkg::SCL_PRE_LO];
   assign tif.scale_val = timer_scaler_r[tmr_pkg::SCL_DIV_HI:tmr_pkg::SCL_DIV_LO];

   tmr_divider u_div (
      .clk (clk),
      .rst (rst),
      .tif (tif.div)
   );

   // ------------------------------------------------------------------
   // counter and waveform
   // ------------------------------------------------------------------
   always_comb begin
      counter_nxt = timer_counter_value_r;
      wave_nxt    = wave_r;
      wrap_evt    = 1'b0;
      pwm_evt     = 1'b0;
      if (tif.tick) begin
         if (!pwm_mode) begin
            if (timer_counter_value_r >= timer_bound_r) begin
               counter_nxt = '0;
               wave_nxt    = ~wave_r;
               wrap_evt    = 1'b1;
            end else begin
               counter_nxt = timer_counter_value_r + 8'h01;
            end
         end else begin
            // pwm period is fixed by resolution; bound sets the duty
            if (timer_counter_value_r >= pwm_last) begin
               counter_nxt = '0;
               pwm_evt     = 1'b1;
            end else begin
               counter_nxt = timer_counter_value_r + 8'h01;
            end
            wave_nxt = (counter_nxt <= timer_bound_r);
         end
      end
   end

   // software load wins over a coincident tick
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_counter_value_r <= tmr_pkg::RST_BYTE;
      end else if (wr_counter) begin
         timer_counter_value_r <= wr_data;
      end else begin
         timer_counter_value_r <= counter_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wave_r <= 1'b0;
      end else begin
         wave_r <= wave_nxt;
      end
   end

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_control_r <= tmr_pkg::RST_BYTE;
      end else if (wr_control) begin
         timer_control_r <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_scaler_r <= tmr_pkg::RST_BYTE;
      end else if (wr_scaler) begin
         timer_scaler_r <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timer_bound_r <= tmr_pkg::RST_BYTE;
      end else if (wr_bound) begin
         timer_bound_r <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         int_mask_r <= tmr_pkg::RST_INT;
      end else if (wr_mask) begin
         int_mask_r <= wr_data[1:0];
      end
   end

   // ------------------------------------------------------------------
   // interrupt status: read clears, a new event in that cycle survives
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         int_stat_r <= tmr_pkg::RST_INT;
      end else begin
         if (rd_stat) begin
            int_stat_r <= tmr_pkg::RST_INT;
         end
         if (wrap_evt) begin
            int_stat_r[tmr_pkg::INT_WRAP_BIT] <= 1'b1;
         end
         if (pwm_evt) begin
            int_stat_r[tmr_pkg::INT_PWM_BIT] <= 1'b1;
         end
      end
   end

   // registered, so it follows the stored status bits one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= tmr_pkg::RST_BYTE;
      end else if (rd_en) begin
         unique case (addr)
            tmr_pkg::OFF_CONTROL:  rd_data <= timer_control_r;
            tmr_pkg::OFF_SCALER:   rd_data <= timer_scaler_r;
            tmr_pkg::OFF_COUNTER:  rd_data <= timer_counter_value_r;
            tmr_pkg::OFF_BOUND:    rd_data <= timer_bound_r;
            tmr_pkg::OFF_INT_STAT: rd_data <= {6'h00, int_stat_r};
            tmr_pkg::OFF_INT_MASK: rd_data <= {6'h00, int_mask_r};
            default:               rd_data <= tmr_pkg::RST_BYTE;
         endcase
      end else begin
         rd_data <= tmr_pkg::RST_BYTE;
      end
   end

   // ------------------------------------------------------------------
   // output pin routing
   // ------------------------------------------------------------------
   // unselected pins are released so the port logic can reuse them
   always_ff @(posedge clk) begin
      if (rst) begin
         out_pin_a    <= 1'b0;
         out_pin_a_oe <= 1'b0;
         out_pin_b    <= 1'b0;
         out_pin_b_oe <= 1'b0;
         out_pin_c    <= 1'b0;
         out_pin_c_oe <= 1'b0;
      end else begin
         out_pin_a    <= wave_nxt && (pin_sel == tmr_pkg::PIN_SEL_A);
         out_pin_a_oe <= (pin_sel == tmr_pkg::PIN_SEL_A);
         out_pin_b    <= wave_nxt && (pin_sel == tmr_pkg::PIN_SEL_B);
         out_pin_b_oe <= (pin_sel == tmr_pkg::PIN_SEL_B);
         out_pin_c    <= wave_nxt && (pin_sel == tmr_pkg::PIN_SEL_C);
         out_pin_c_oe <= (pin_sel == tmr_pkg::PIN_SEL_C);
      end
   end
endmodule

/* File: shared/tmr_pkg.sv */
package tmr_pkg;
   // register word offsets on the local port
   localparam int unsigned ADDR_W      = 3;
   localparam logic [2:0] OFF_CONTROL  = 3'h0;
   localparam logic [2:0] OFF_SCALER   = 3'h1;
   localparam logic [2:0] OFF_COUNTER  = 3'h2;
   localparam logic [2:0] OFF_BOUND    = 3'h3;
   localparam logic [2:0] OFF_INT_STAT = 3'h4;
   localparam logic [2:0] OFF_INT_MASK = 3'h5;

   // reset values
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [1:0] RST_INT      = 2'h0;

   // control field layout
   localparam int unsigned CTL_SRC_HI  = 7;
   localparam int unsigned CTL_SRC_LO  = 4;
   localparam int unsigned CTL_PIN_HI  = 3;
   localparam int unsigned CTL_PIN_LO  = 2;
   localparam int unsigned CTL_PWM_BIT = 1;

   // scaler field layout
   localparam int unsigned SCL_6BIT_BIT = 7;
   localparam int unsigned SCL_PRE_HI   = 6;
   localparam int unsigned SCL_PRE_LO   = 5;
   localparam int unsigned SCL_DIV_HI   = 4;
   localparam int unsigned SCL_DIV_LO   = 0;

   // interrupt status / mask bits
   localparam int unsigned INT_WRAP_BIT = 0;
   localparam int unsigned INT_PWM_BIT  = 1;

   // clock source codes
   typedef enum logic [3:0] {
      SRC_OFF       = 4'h0,
      SRC_SYSCLK    = 4'h1,
      SRC_FAST_OSC  = 4'h2,
      SRC_SLOW_OSC  = 4'h3,
      SRC_CRYSTAL   = 4'h4,
      SRC_COMPARE   = 4'h5,
      SRC_PIN_A     = 4'h6,
      SRC_PIN_B     = 4'h7,
      SRC_PIN_C     = 4'h8
   } tmr_src_e;

   // external source vector positions
   localparam int unsigned NUM_EXT      = 7;
   localparam int unsigned EXT_FAST     = 0;
   localparam int unsigned EXT_SLOW     = 1;
   localparam int unsigned EXT_CRYSTAL  = 2;
   localparam int unsigned EXT_COMPARE  = 3;
   localparam int unsigned EXT_PIN_A    = 4;
   localparam int unsigned EXT_PIN_B    = 5;
   localparam int unsigned EXT_PIN_C    = 6;

   // output pin selection codes
   localparam logic [1:0] PIN_NONE     = 2'h0;
   localparam logic [1:0] PIN_SEL_B    = 2'h1;
   localparam logic [1:0] PIN_SEL_A    = 2'h2;
   localparam logic [1:0] PIN_SEL_C    = 2'h3;

   // pre-scaler terminal counts (divide minus one)
   localparam logic [5:0] PRE_LAST_1   = 6'h00;
   localparam logic [5:0] PRE_LAST_4   = 6'h03;
   localparam logic [5:0] PRE_LAST_16  = 6'h0F;
   localparam logic [5:0] PRE_LAST_64  = 6'h3F;

   // pwm terminal counts
   localparam logic [7:0] PWM8_LAST    = 8'hFF;
   localparam logic [7:0] PWM6_LAST    = 8'h3F;
endpackage

/* File: shared/tmr_tick_if.sv */
`timescale 1ns/1ps
interface tmr_tick_if;
   logic       src_tick;
   logic [1:0] pre_sel;
   logic [4:0] scale_val;
   logic       tick;

   modport div  (input src_tick, input pre_sel, input scale_val, output tick);
   modport core (output src_tick, output pre_sel, output scale_val, input tick);
endinterface

/* File: src/tmr_edge_det.sv */
`timescale 1ns/1ps
module tmr_edge_det #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] prev_r;

   // inputs are already synchronous; one stage remembers the old level
   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= '0;
      end else begin
         prev_r <= level_in;
      end
   end

   assign rise = level_in & ~prev_r;
endmodule

/* File: src/tmr_divider.sv */
`timescale 1ns/1ps
module tmr_divider (
   input  wire logic clk,
   input  wire logic rst,
   tmr_tick_if.div   tif
);
   logic [5:0] pre_cnt_r;
   logic [4:0] scl_cnt_r;
   logic [5:0] pre_last;
   logic       pre_tick;

   always_comb begin
      unique case (tif.pre_sel)
         2'h0:    pre_last = tmr_pkg::PRE_LAST_1;
         2'h1:    pre_last = tmr_pkg::PRE_LAST_4;
         2'h2:    pre_last = tmr_pkg::PRE_LAST_16;
         default: pre_last = tmr_pkg::PRE_LAST_64;
      endcase
   end

   // >= so a smaller divide written mid-count restarts at once
   assign pre_tick = tif.src_tick && (pre_cnt_r >= pre_last);

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_cnt_r <= '0;
      end else if (tif.src_tick) begin
         pre_cnt_r <= pre_tick ? 6'h00 : pre_cnt_r + 6'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_cnt_r <= '0;
         tif.tick  <= 1'b0;
      end else begin
         tif.tick <= 1'b0;
         if (pre_tick) begin
            if (scl_cnt_r >= tif.scale_val) begin
               scl_cnt_r <= '0;
               tif.tick  <= 1'b1;
            end else begin
               scl_cnt_r <= scl_cnt_r + 5'h01;
            end
         end
      end
   end
endmodule

/* File: testbench/tmr_props.sv */
`timescale 1ns/1ps
module tmr_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] rd_data,
   input wire logic       out_pin_a,
   input wire logic       out_pin_a_oe,
   input wire logic       out_pin_b,
   input wire logic       out_pin_b_oe,
   input wire logic       out_pin_c,
   input wire logic       out_pin_c_oe,
   input wire logic       irq
);
   logic [1:0] mask_r;
   always_ff @(posedge clk) begin
      if (rst)
         mask_r <= 2'h0;
      else if (wr_en && addr == tmr_pkg::OFF_INT_MASK)
         mask_r <= wr_data[1:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_idle;
      !$past(rd_en) |-> rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped;
      rd_en && addr[2:1] == 2'h3 |=> rd_data == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_readback;
      wr_en && addr inside {3'h0, 3'h1, 3'h3} ##1 rd_en && addr == $past(addr)
         |=> rd_data == $past(wr_data, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("register readback wrong");
   property p_oe_one;
      $onehot0({out_pin_a_oe, out_pin_b_oe, out_pin_c_oe});
   endproperty
   a_oe_one: assert property (p_oe_one) else $error("more than one pin driven");
   property p_pin_off;
      ({out_pin_a, out_pin_b, out_pin_c} & ~{out_pin_a_oe, out_pin_b_oe, out_pin_c_oe}) == 3'h0;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("unselected pin not low");
   // three quiet cycles cover either output latency
   property p_oe_dec;
      wr_en && addr == 3'h0 ##1 !(wr_en && addr == 3'h0) [*3]
         |-> {out_pin_c_oe, out_pin_a_oe, out_pin_b_oe}
             == 3'((4'h1 << $past(wr_data[3:2], 3)) >> 1);
   endproperty
   a_oe_dec: assert property (p_oe_dec) else $error("pin enable decode wrong");
   property p_irq_mask;
      irq |-> $past(mask_r) != 2'h0 || mask_r != 2'h0;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
   property p_irq_off;
      wr_en && addr == 3'h5 && wr_data[1:0] == 2'h0 |-> ##2 !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt stays after mask");
   c_irq: cover property ($rose(irq));
   c_wave: cover property ($rose(out_pin_a));
   c_back: cover property (wr_en && addr == 3'h3 ##1 rd_en && addr == 3'h3);
endmodule
bind tmr_top tmr_props u_props (
   .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .out_pin_a(out_pin_a), .out_pin_a_oe(out_pin_a_oe),
   .out_pin_b(out_pin_b), .out_pin_b_oe(out_pin_b_oe), .out_pin_c(out_pin_c),
   .out_pin_c_oe(out_pin_c_oe), .irq(irq)
);

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        clk;
   logic        rst;
   logic [2:0]  addr;
   logic [7:0]  wr_data;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rd_data;
   logic [6:0]  src_lvl;
   logic [6:0]  src_en;
   logic        tgl;
   logic [2:0]  pin;
   logic [2:0]  oe;
   logic        irq;
   logic        rd_pend;
   logic [15:0] expq[$];
   logic [15:0] e;
   int          n_mismatch;
   int          checked;
   int          pi;
   int          pin_of[4] = '{0, 1, 0, 2};
   logic [2:0]  oe_of[4] = '{3'h0, 3'h2, 3'h1, 3'h4};
   tmr_top u_dut (
      .clk               (clk),
      .rst               (rst),
      .addr              (addr),
      .wr_data           (wr_data),
      .wr_en             (wr_en),
      .rd_en             (rd_en),
      .rd_data           (rd_data),
      .fast_internal_osc (src_lvl[0]),
      .slow_internal_osc (src_lvl[1]),
      .crystal_osc       (src_lvl[2]),
      .comparator_out    (src_lvl[3]),
      .clk_in_pin_a      (src_lvl[4]),
      .clk_in_pin_b      (src_lvl[5]),
      .clk_in_pin_c      (src_lvl[6]),
      .out_pin_a         (pin[0]),
      .out_pin_a_oe      (oe[0]),
      .out_pin_b         (pin[1]),
      .out_pin_b_oe      (oe[1]),
      .out_pin_c         (pin[2]),
      .out_pin_c_oe      (oe[2]),
      .irq               (irq)
   );
   initial clk = 1'b0;
   always #50 clk = ~clk;
   // selected source edge every 4 clocks
   always @(posedge clk) begin
      tgl <= ~tgl;
      if (tgl)
         src_lvl <= src_lvl ^ src_en;
   end
   task automatic chk(string nm, logic [15:0] x, logic [15:0] got);
      checked++;
      if (got !== x) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, x, got);
      end
   endtask
   always @(posedge clk) begin
      if (rd_pend) begin
         e = expq.pop_front();
         chk("rd_data", {8'h00, e[7:0]}, {8'h00, rd_data & e[15:8]});
      end
      rd_pend <= rd_en;
   end
   task automatic results();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] x, logic [7:0] m = 8'hFF);
      expq.push_back({m, x & m});
      addr <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge clk);
   endtask
   task automatic idle(int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   // index 3 watches the interrupt line
   task automatic wt(int i, logic v, output int n);
      n = 0;
      while ((i == 3 ? irq : pin[i]) !== v) begin
         @(posedge clk);
         n++;
         if (n > 20000) begin
            n_mismatch++;
            $display("[FAIL] wait expected %0d seen timeout", v);
            results();
         end
      end
   endtask
   task automatic cfg(logic [7:0] c, logic [7:0] s, logic [7:0] b);
      wr(tmr_pkg::OFF_CONTROL, 8'h00);
      wr(tmr_pkg::OFF_COUNTER, 8'h00);
      wr(tmr_pkg::OFF_SCALER, s);
      wr(tmr_pkg::OFF_BOUND, b);
      wr(tmr_pkg::OFF_CONTROL, c);
      // pin enables settle one edge after the control write
      idle(2);
   endtask
   task automatic meas(output int hi, output int lo);
      int n;
      wt(pi, 1'b0, n);
      wt(pi, 1'b1, n);
      wt(pi, 1'b0, hi);
      wt(pi, 1'b1, lo);
   endtask
   task automatic per(logic [3:0] c, logic [1:0] sl, logic [1:0] p, logic [4:0] s,
                      logic [7:0] k, int m);
      int hi;
      int lo;
      int t;
      t = (int'(k) + 1) * (1 << (2 * p)) * (int'(s) + 1) * m;
      pi = pin_of[sl];
      cfg({c, sl, 2'b00}, {1'b0, p, s}, k);
      chk("pin_oe", {13'h0, oe_of[sl]}, {13'h0, oe});
      meas(hi, lo);
      chk("half_high", t, hi);
      chk("half_low", t, lo);
   endtask
   task automatic pwm(logic six, logic [7:0] k);
      int hi;
      int lo;
      int bad;
      pi = 0;
      cfg({4'h1, 2'b10, 2'b10}, {six, 7'h00}, k);
      if (k == (six ? 8'h3F : 8'hFF)) begin
         bad = 0;
         idle(20);
         repeat (600) @(posedge clk) bad += (pin[0] !== 1'b1);
         chk("pwm_full", 0, bad);
      end else begin
         meas(hi, lo);
         chk("pwm_high", k + 1, hi);
         chk("pwm_low", (six ? 64 : 256) - k - 1, lo);
      end
   endtask
   initial begin
      logic [7:0] d;
      int n;
      {rst, tgl, rd_pend} = 3'b100;
      {addr, wr_data, wr_en, rd_en, src_lvl, src_en} = '0;
      n_mismatch = 0;
      checked = 0;
      pi = 0;
      void'($urandom(32'h51E8E227));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      idle(1);
      for (int i = 0; i < 8; i++)
         rd(3'(i), tmr_pkg::RST_BYTE);
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         if (i != 2)
            wr(3'(i), d);
         if (i != 2)
            rd(3'(i), d);
      end
      wr(3'h6, 8'hFF);
      rd(3'h6, 8'h00);
      rd(tmr_pkg::OFF_BOUND, d);
      wr(tmr_pkg::OFF_INT_MASK, 8'hFF);
      rd(tmr_pkg::OFF_INT_MASK, 8'h03);
      wr(tmr_pkg::OFF_INT_MASK, 8'h00);
      // a stopped source must hold a loaded count
      wr(tmr_pkg::OFF_CONTROL, 8'h00);
      wr(tmr_pkg::OFF_COUNTER, 8'hA5);
      idle(6);
      rd(tmr_pkg::OFF_COUNTER, 8'hA5);
      for (int sl = 1; sl < 4; sl++)
         per(tmr_pkg::SRC_SYSCLK, 2'(sl), 2'h0, 5'h0, 8'h1, 1);
      for (int p = 0; p < 4; p++)
         per(tmr_pkg::SRC_SYSCLK, 2'h2, 2'(p), 5'($urandom_range(3)),
             8'($urandom_range(7)), 1);
      per(tmr_pkg::SRC_SYSCLK, 2'h2, 2'h0, 5'h1F, 8'h0, 1);
      for (int c = 2; c < 9; c++) begin
         src_en <= 7'(1 << (c - 2));
         per(4'(c), 2'h2, 2'h0, 5'h0, 8'h1, 4);
      end
      src_en <= 7'h00;
      foreach (d[i]) begin
         pwm(1'b0, i < 2 ? 8'(i * 254) : 8'($urandom_range(253, 1)));
      end
      pwm(1'b0, 8'hFF);
      pwm(1'b1, 8'h00);
      pwm(1'b1, 8'($urandom_range(62, 1)));
      pwm(1'b1, 8'h3F);
      rd(tmr_pkg::OFF_INT_STAT, 8'h03);
      wr(tmr_pkg::OFF_INT_MASK, 8'h01);
      idle(2);
      chk("irq_idle", 0, {15'h0, irq});
      per(tmr_pkg::SRC_SYSCLK, 2'h2, 2'h0, 5'h0, 8'h1, 1);
      wt(3, 1'b1, n);
      wr(tmr_pkg::OFF_CONTROL, 8'h00);
      idle(4);
      rd(tmr_pkg::OFF_INT_STAT, 8'h01, 8'h01);
      rd(tmr_pkg::OFF_INT_STAT, 8'h00, 8'h01);
      idle(3);
      chk("irq_clear", 0, {15'h0, irq});
      wr(tmr_pkg::OFF_INT_MASK, 8'h00);
      cfg(8'h18, 8'h00, 8'h1);
      idle(40);
      chk("irq_masked", 0, {15'h0, irq});
      wr(tmr_pkg::OFF_INT_MASK, 8'h01);
      idle(1);
      wt(3, 1'b1, n);
      wr(tmr_pkg::OFF_INT_MASK, 8'h00);
      idle(4);
      results();
   end
endmodule
